// file: hw/fieldbus_master_status.sv
// Purpose: indicator drive and cyclic process-data exchange of a fieldbus master
// Assumes: cpu run, init and slave-online inputs come from logic on i_mclk
// Notes:   register port answers every read in the next cycle
//
// What this block does
// R1 - run lamp steady green while cpu runs
// R2 - run lamp off while cpu stopped
// R3 - health lamp flashes red once, then green
// R4 - failed init shows health lamp red
// R5 - bus lamp steady green when connected
// R6 - bus lamp flashes green without configuration
// R7 - bus lamp steady red, all slaves offline
// R8 - bus lamp flashes red, some slaves offline
// R9 - no exchange data before link established
// R10 - six words copied both ways once established
// R11 - exchange repeats cyclically
// R12 - all offline wins over partial offline
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module fieldbus_master_status #(
  parameter int unsigned BLINK_CYC = fbm_pkg::BLINK_HALF_CYC,
  parameter int unsigned XCHG_CYC  = fbm_pkg::XCHG_PERIOD_CYC,
  parameter int          N_SLAVES  = fbm_pkg::N_SLAVES
) (
  input  wire logic                                       i_mclk,
  input  wire logic                                       i_arst_n,
  input  wire logic [fbm_pkg::ADDR_W-1:0]                 i_addr,
  input  wire logic [fbm_pkg::WORD_W-1:0]                 i_wdata,
  input  wire logic                                       i_wr,
  input  wire logic                                       i_rd,
  output logic      [fbm_pkg::WORD_W-1:0]                 o_rdata,
  output logic                                            o_irq,
  input  wire logic                                       i_cpu_run,
  input  wire logic                                       i_init_done,
  input  wire logic                                       i_init_fail,
  input  wire logic [N_SLAVES-1:0]                        i_slave_online,
  input  wire logic [fbm_pkg::N_WORDS*fbm_pkg::WORD_W-1:0] i_slave_words,
  output logic      [fbm_pkg::N_WORDS*fbm_pkg::WORD_W-1:0] o_slave_words,
  output logic                                            o_xchg_done,
  output logic                                            o_run_green,
  output logic                                            o_sys_green,
  output logic                                            o_sys_red,
  output logic                                            o_bus_green,
  output logic                                            o_bus_red
);
  localparam int W  = fbm_pkg::WORD_W;
  localparam int NW = fbm_pkg::N_WORDS;
  localparam int IW = fbm_pkg::IDX_W;
  localparam logic [IW-1:0] LAST_IDX = IW'(NW - 1);
  localparam logic [fbm_pkg::ADDR_W-1:0] NW_A = fbm_pkg::ADDR_W'(NW);
  // ---------------------------------------------------------------
  // rate sources
  // ---------------------------------------------------------------
  logic blink_tick, blink_phase, xchg_tick;
  rate_divider #(.PERIOD(BLINK_CYC)) u_blink (
    .i_mclk  (i_mclk),
    .i_arst_n(i_arst_n),
    .o_tick  (blink_tick),
    .o_phase (blink_phase)
  );
  rate_divider #(.PERIOD(XCHG_CYC)) u_xchg (
    .i_mclk  (i_mclk),
    .i_arst_n(i_arst_n),
    .o_tick  (xchg_tick),
    .o_phase ()
  );
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic                             ctrl_cfg_q, ctrl_cfg_d;
  logic [N_SLAVES-1:0]              slv_cfg_q, slv_cfg_d;
  logic [N_SLAVES-1:0]              online_q, online_d;
  logic [fbm_pkg::IRQ_W-1:0]        irq_stat_q, irq_stat_d;
  logic [fbm_pkg::IRQ_W-1:0]        irq_mask_q, irq_mask_d;
  logic [W-1:0]                     rdata_d;
  logic                             irq_d, est_q, est_d;
  fbm_pkg::sys_state_t              sys_q, sys_d;
  fbm_pkg::xchg_state_t             xs_q, xs_d;
  logic [IW-1:0]                    idx_q, idx_d, widx_q, widx_d;
  logic                             wr_pend_q, wr_pend_d, done_d, walk_seen_q, walk_seen_d;
  logic [NW-1:0][W-1:0]             slave_words_q, slave_words_d;
  logic [NW-1:0][W-1:0]             master_in_q, master_in_d;
  logic [NW-1:0][W-1:0]             rx_words;
  logic                             run_d, sys_g_d, sys_r_d, bus_g_d, bus_r_d;
  logic [N_SLAVES-1:0]              online_cfg;
  logic                             cfg_ok, all_on, all_off;
  logic                             mem_we;
  logic [IW-1:0]                    mem_waddr;
  logic [W-1:0]                     mem_rdata;
  logic [fbm_pkg::ADDR_W-1:0]       out_off, in_off;
  logic                             in_out_rng, in_in_rng;
  assign rx_words      = i_slave_words;
  assign o_slave_words = slave_words_q;
  // ---------------------------------------------------------------
  // master output area
  // ---------------------------------------------------------------
  word_store #(.W(W), .DEPTH(NW), .AW(IW)) u_out_area (
    .i_mclk  (i_mclk),
    .i_arst_n(i_arst_n),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (i_wdata),
    .i_raddr (idx_q),
    .o_rdata (mem_rdata)
  );
  // ---------------------------------------------------------------
  // link condition
  // ---------------------------------------------------------------
  always_comb begin
    online_cfg = i_slave_online & slv_cfg_q;
    cfg_ok     = ctrl_cfg_q && (slv_cfg_q != '0);
    all_on     = (online_cfg == slv_cfg_q);
    all_off    = (online_cfg == '0);
    est_d      = cfg_ok && all_on;
    online_d   = online_cfg;
  end
  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  always_comb begin
    sys_d   = sys_q;
    sys_g_d = 1'b0;
    sys_r_d = 1'b0;
    run_d   = i_cpu_run;                            // [R1] [R2]
    case (sys_q)
      fbm_pkg::SYS_FLASH: begin
        sys_r_d = 1'b1;                             // [R3]
        if (blink_tick) begin
          sys_d = fbm_pkg::SYS_WAIT;
        end
      end
      fbm_pkg::SYS_WAIT: begin
        if (i_init_fail) begin
          sys_d = fbm_pkg::SYS_FAIL;                // [R4]
        end else if (i_init_done) begin
          sys_d = fbm_pkg::SYS_OK;                  // [R3]
        end
      end
      fbm_pkg::SYS_OK: begin
        sys_g_d = 1'b1;                             // [R3]
        if (i_init_fail) begin
          sys_d = fbm_pkg::SYS_FAIL;
        end
      end
      fbm_pkg::SYS_FAIL: begin
        // held until the next reset
        sys_r_d = blink_phase;                      // [R4]
      end
      default: sys_d = fbm_pkg::SYS_FLASH;
    endcase
    bus_g_d = 1'b0;
    bus_r_d = 1'b0;
    if (!cfg_ok) begin
      bus_g_d = blink_phase;                        // [R6]
    end else if (all_on) begin
      bus_g_d = 1'b1;                               // [R5]
    end else if (all_off) begin
      bus_r_d = 1'b1;                               // [R7] [R12]
    end else begin
      bus_r_d = blink_phase;                        // [R8]
    end
  end
  // ---------------------------------------------------------------
  // cyclic exchange
  // ---------------------------------------------------------------
  always_comb begin
    xs_d          = xs_q;
    idx_d         = idx_q;
    widx_d        = widx_q;
    wr_pend_d     = 1'b0;
    done_d        = 1'b0;
    walk_seen_d   = walk_seen_q | o_xchg_done;
    slave_words_d = slave_words_q;
    master_in_d   = master_in_q;
    case (xs_q)
      fbm_pkg::XS_IDLE: begin
        if (xchg_tick && est_q) begin
          xs_d  = fbm_pkg::XS_RUN;                  // [R11]
          idx_d = '0;
        end
      end
      fbm_pkg::XS_RUN: begin
        wr_pend_d = 1'b1;
        widx_d    = idx_q;
        idx_d     = idx_q + 1'b1;
        if (idx_q == LAST_IDX) begin
          xs_d  = fbm_pkg::XS_IDLE;
          idx_d = '0;
        end
      end
      default: xs_d = fbm_pkg::XS_IDLE;
    endcase
    if (wr_pend_q) begin
      slave_words_d[widx_q] = mem_rdata;            // [R10]
      master_in_d[widx_q]   = rx_words[widx_q];     // [R10]
      done_d                = (widx_q == LAST_IDX);
    end
    // a lost link stops the walk and blanks both areas
    if (!est_q) begin
      xs_d          = fbm_pkg::XS_IDLE;
      idx_d         = '0;
      wr_pend_d     = 1'b0;
      done_d        = 1'b0;
      slave_words_d = '0;                           // [R9]
      master_in_d   = '0;                           // [R9]
    end
  end
  // ---------------------------------------------------------------
  // register port and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    out_off    = i_addr - fbm_pkg::A_OUT_BASE;
    in_off     = i_addr - fbm_pkg::A_IN_BASE;
    in_out_rng = (i_addr >= fbm_pkg::A_OUT_BASE) && (out_off < NW_A);
    in_in_rng  = (i_addr >= fbm_pkg::A_IN_BASE) && (in_off < NW_A);
    mem_we     = i_wr && in_out_rng;
    mem_waddr  = out_off[IW-1:0];
    ctrl_cfg_d = ctrl_cfg_q;
    slv_cfg_d  = slv_cfg_q;
    irq_mask_d = irq_mask_q;
    if (i_wr) begin
      case (i_addr)
        fbm_pkg::A_CTRL:     ctrl_cfg_d = i_wdata[fbm_pkg::CTRL_CFG_BIT];
        fbm_pkg::A_SLV_CFG:  slv_cfg_d  = i_wdata[N_SLAVES-1:0];
        fbm_pkg::A_IRQ_MASK: irq_mask_d = i_wdata[fbm_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    rdata_d = '0;
    if (i_rd) begin
      case (i_addr)
        fbm_pkg::A_CTRL:     rdata_d[fbm_pkg::CTRL_CFG_BIT] = ctrl_cfg_q;
        fbm_pkg::A_SLV_CFG:  rdata_d[N_SLAVES-1:0] = slv_cfg_q;
        fbm_pkg::A_STATUS: begin
          rdata_d[fbm_pkg::ST_EST_BIT]     = est_q;
          rdata_d[fbm_pkg::ST_INIT_OK_BIT] = (sys_q == fbm_pkg::SYS_OK);
          rdata_d[fbm_pkg::ST_FAIL_BIT]    = (sys_q == fbm_pkg::SYS_FAIL);
          rdata_d[fbm_pkg::ST_RUN_BIT]     = o_run_green;
          rdata_d[fbm_pkg::ST_ONLINE_LSB +: N_SLAVES] = online_q;
        end
        fbm_pkg::A_IRQ_STAT: rdata_d[fbm_pkg::IRQ_W-1:0] = irq_stat_q;
        fbm_pkg::A_IRQ_MASK: rdata_d[fbm_pkg::IRQ_W-1:0] = irq_mask_q;
        default: begin
          if (in_in_rng) begin
            rdata_d = master_in_q[in_off[IW-1:0]];
          end
        end
      endcase
    end
    // read clears, but an event in the same cycle survives
    irq_stat_d = (i_rd && i_addr == fbm_pkg::A_IRQ_STAT) ? '0 : irq_stat_q;
    irq_stat_d[fbm_pkg::IRQ_UP_BIT]   |= est_d && !est_q;
    irq_stat_d[fbm_pkg::IRQ_DOWN_BIT] |= !est_d && est_q;
    irq_stat_d[fbm_pkg::IRQ_FAIL_BIT] |= (sys_d == fbm_pkg::SYS_FAIL) && (sys_q != fbm_pkg::SYS_FAIL);
    irq_stat_d[fbm_pkg::IRQ_OFF_BIT]  |= |(online_q & slv_cfg_q & ~online_cfg);
    irq_d = |(irq_stat_q & irq_mask_q);
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_cfg_q    <= fbm_pkg::CTRL_CFG_RST;
      slv_cfg_q     <= fbm_pkg::SLV_CFG_RST;
      irq_mask_q    <= fbm_pkg::IRQ_MASK_RST;
      irq_stat_q    <= '0;
      online_q      <= '0;
      est_q         <= 1'b0;
      sys_q         <= fbm_pkg::SYS_FLASH;
      xs_q          <= fbm_pkg::XS_IDLE;
      idx_q         <= '0;
      widx_q        <= '0;
      wr_pend_q     <= 1'b0;
      walk_seen_q   <= 1'b0;
      slave_words_q <= '0;
      master_in_q   <= '0;
      o_rdata       <= '0;
      o_irq         <= 1'b0;
      o_xchg_done   <= 1'b0;
      o_run_green   <= 1'b0;
      o_sys_green   <= 1'b0;
      o_sys_red     <= 1'b0;
      o_bus_green   <= 1'b0;
      o_bus_red     <= 1'b0;
    end else begin
      ctrl_cfg_q    <= ctrl_cfg_d;
      slv_cfg_q     <= slv_cfg_d;
      irq_mask_q    <= irq_mask_d;
      irq_stat_q    <= irq_stat_d;
      online_q      <= online_d;
      est_q         <= est_d;
      sys_q         <= sys_d;
      xs_q          <= xs_d;
      idx_q         <= idx_d;
      widx_q        <= widx_d;
      wr_pend_q     <= wr_pend_d;
      walk_seen_q   <= walk_seen_d;
      slave_words_q <= slave_words_d;
      master_in_q   <= master_in_d;
      o_rdata       <= rdata_d;
      o_irq         <= irq_d;
      o_xchg_done   <= done_d;
      o_run_green   <= run_d;
      o_sys_green   <= sys_g_d;
      o_sys_red     <= sys_r_d;
      o_bus_green   <= bus_g_d;
      o_bus_red     <= bus_r_d;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  run_on_a: assert property (i_cpu_run |=> o_run_green) else $error("run lamp not green"); // [R1]
  run_off_a: assert property (!i_cpu_run |=> !o_run_green) else $error("run lamp not off"); // [R2]
  sys_flash_a: assert property ((sys_q == fbm_pkg::SYS_FLASH) |=> o_sys_red && !o_sys_green) // [R3]
    else $error("power-on flash not red");
  sys_ok_a: assert property ((sys_q == fbm_pkg::SYS_WAIT && i_init_done && !i_init_fail) // [R3]
    |=> ##1 (o_sys_green && !o_sys_red)) else $error("health lamp not green after init");
  sys_fail_a: assert property ((sys_q == fbm_pkg::SYS_WAIT && i_init_fail) // [R4]
    |=> (sys_q == fbm_pkg::SYS_FAIL) ##1 (!o_sys_green && o_sys_red == $past(blink_phase)))
    else $error("failed init not shown red");
  bus_green_a: assert property (est_q |-> o_bus_green && !o_bus_red) else $error("bus lamp not green"); // [R5]
  bus_nocfg_a: assert property (!cfg_ok |=> !o_bus_red && o_bus_green == $past(blink_phase)) // [R6]
    else $error("bus lamp not flashing green");
  bus_alloff_a: assert property ((cfg_ok && all_off) |=> o_bus_red && !o_bus_green) // [R7] [R12]
    else $error("bus lamp not steady red");
  bus_part_a: assert property ((cfg_ok && !all_off && !all_on) |=> !o_bus_green // [R8]
    && o_bus_red == $past(blink_phase)) else $error("bus lamp not flashing red");
  zero_link_a: assert property (!est_q |=> slave_words_q == '0 && master_in_q == '0) // [R9]
    else $error("data moved without link");
  copy_word_a: assert property ((wr_pend_q && est_q) |=> slave_words_q[$past(widx_q)] == $past(mem_rdata) // [R10]
    && master_in_q[$past(widx_q)] == $past(rx_words[widx_q])) else $error("exchange word not copied");
  cycle_start_a: assert property ((est_q && xchg_tick && xs_q == fbm_pkg::XS_IDLE) // [R11]
    |=> xs_q == fbm_pkg::XS_RUN ##[1:6] xs_q == fbm_pkg::XS_IDLE) else $error("exchange cycle not run");
  irq_level_a: assert property (|(irq_stat_q & irq_mask_q) |=> o_irq) else $error("interrupt not raised");
  link_up_c: cover property (!est_q ##1 est_q);
  init_fail_c: cover property (sys_q == fbm_pkg::SYS_FAIL);
  part_off_c: cover property (cfg_ok && !all_off && !all_on);
  // walk_seen_q stands in for a gap counter: real periods are far beyond a delay range
  xchg_done_c: cover property (o_xchg_done && walk_seen_q);
endmodule

// file: hw/rate_divider.sv
// Purpose: free-running divider giving a one-cycle tick and a square phase
// Assumes: PERIOD of at least 2 cycles
// Notes:   phase toggles on every tick, so it runs at half the tick rate
`timescale 1ns/1ps
module rate_divider #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  output logic      o_tick,
  output logic      o_phase
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          tick_d, phase_d;

  always_comb begin
    tick_d  = (cnt_q == LAST);
    cnt_d   = tick_d ? '0 : cnt_q + 1'b1;
    phase_d = tick_d ? ~o_phase : o_phase;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q   <= '0;
      o_tick  <= 1'b0;
      o_phase <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      o_tick  <= tick_d;
      o_phase <= phase_d;
    end
  end
endmodule

// file: hw/word_store.sv
// Purpose: small word memory holding the master output area
// Assumes: one write port, one read port, same clock
// Notes:   read data is registered; cleared at reset so no unknowns reach the link
`timescale 1ns/1ps
module word_store #(
  parameter int W     = 16,
  parameter int DEPTH = 6,
  parameter int AW    = 3
) (
  input  wire logic          i_mclk,
  input  wire logic          i_arst_n,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  logic [DEPTH-1:0][W-1:0] mem_q;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_q   <= '0;
      o_rdata <= '0;
    end else begin
      if (i_we) begin
        mem_q[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule

// file: shared/fbm_pkg.sv
// Purpose: shared constants and types for the fieldbus master status block
// Assumes: 100 MHz system clock, 16-bit register port
// Notes:   register indices double as word addresses on the plain port
package fbm_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int BLINK_HALF_MS   = 250;
  localparam int BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int XCHG_PERIOD_US  = 100;
  localparam int XCHG_PERIOD_CYC = CLK_HZ / 1_000_000 * XCHG_PERIOD_US;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int WORD_W   = 16;
  localparam int N_WORDS  = 6;
  localparam int IDX_W    = 3;
  localparam int ADDR_W   = 5;
  localparam int N_SLAVES = 8;
  localparam int IRQ_W    = 4;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL     = 5'h00;
  localparam logic [ADDR_W-1:0] A_SLV_CFG  = 5'h01;
  localparam logic [ADDR_W-1:0] A_STATUS   = 5'h02;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 5'h03;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 5'h04;
  localparam logic [ADDR_W-1:0] A_OUT_BASE = 5'h08;
  localparam logic [ADDR_W-1:0] A_IN_BASE  = 5'h10;
  localparam int CTRL_CFG_BIT   = 0;
  localparam int ST_EST_BIT     = 0;
  localparam int ST_INIT_OK_BIT = 1;
  localparam int ST_FAIL_BIT    = 2;
  localparam int ST_RUN_BIT     = 3;
  localparam int ST_ONLINE_LSB  = 8;
  localparam int IRQ_UP_BIT     = 0;
  localparam int IRQ_DOWN_BIT   = 1;
  localparam int IRQ_FAIL_BIT   = 2;
  localparam int IRQ_OFF_BIT    = 3;
  localparam logic                CTRL_CFG_RST = 1'b0;
  localparam logic [N_SLAVES-1:0] SLV_CFG_RST  = 8'h00;
  localparam logic [IRQ_W-1:0]    IRQ_MASK_RST = 4'h0;
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SYS_FLASH, SYS_WAIT, SYS_OK, SYS_FAIL} sys_state_t;
  typedef enum logic {XS_IDLE, XS_RUN} xchg_state_t;
endpackage

// file: tb/fieldbus_master_status_tb.sv
// Purpose: self-checking bench for the fieldbus master status block
// Assumes: short blink and exchange periods set by parameter
// Notes:   reads are checked by a monitor against a queue of expected words
`timescale 1ns/1ps
module fieldbus_master_status_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        i_mclk = 1'b0;
  logic        i_arst_n, i_wr, i_rd, cpu, init_done, init_fail, rd_d = 1'b0;
  logic [4:0]  i_addr;
  logic [15:0] i_wdata;
  logic [7:0]  up, online;
  logic [95:0] ret, tx, sw, rx, ow;
  logic        o_irq, xdone, run_g, sys_g, sys_r, bus_g, bus_r;
  logic [15:0] o_rdata;
  logic [15:0] exp_q[$];
  int          fails = 0, num_checks = 0, cyc = 0, gt, rt, gh, rh, ndone = 0, nd0;
  always #5 i_mclk = ~i_mclk;
  fieldbus_master_status #(.BLINK_CYC(16), .XCHG_CYC(20), .N_SLAVES(8)) fieldbus_master_status_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_cpu_run(cpu), .i_init_done(init_done), .i_init_fail(init_fail),
    .i_slave_online(online), .i_slave_words(tx), .o_slave_words(sw), .o_xchg_done(xdone),
    .o_run_green(run_g), .o_sys_green(sys_g), .o_sys_red(sys_r), .o_bus_green(bus_g), .o_bus_red(bus_r));
  slave_station_model #(.N(8), .W(96)) slave_station_model_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_up(up), .i_ret(ret), .i_rx(sw),
    .o_online(online), .o_tx(tx), .o_rx_q(rx));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask
  task automatic pass(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // lamp pair watched for 40 cycles: toggles and cycles lit
  task automatic watch(input bit system_health_indicator);
    logic g, r, pg, pr;
    gt = 0;
    rt = 0;
    gh = 0;
    rh = 0;
    pg = system_health_indicator ? sys_g : bus_g;
    pr = system_health_indicator ? sys_r : bus_r;
    repeat (40) begin
      pass(1);
      g = system_health_indicator ? sys_g : bus_g;
      r = system_health_indicator ? sys_r : bus_r;
      gt += int'(g !== pg);
      rt += int'(r !== pr);
      gh += int'(g === 1'b1);
      rh += int'(r === 1'b1);
      pg = g;
      pr = r;
    end
  endtask
  task automatic xchg_check;
    int k;
    chk("o_slave_words", sw, ow);
    chk("slave_rx", rx, ow);
    for (k = 0; k < 6; k++) rd(fbm_pkg::A_IN_BASE + 5'(k), ret[16*k +: 16]);
  endtask
  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (rd_d) begin
      chk("o_rdata", o_rdata, exp_q.pop_front());
    end
    rd_d <= i_rd;
    if (xdone === 1'b1) ndone++;
    cyc++;
    if (cyc == 4000) begin
      fails++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(96781));
    {i_arst_n, i_wr, i_rd, cpu, init_done, init_fail} = '0;
    {i_addr, i_wdata, up, ret} = '0;
    for (int k = 0; k < 6; k++) ow[16*k +: 16] = 16'($urandom);
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    pass(1);
    chk("sys_red_boot", {sys_r, sys_g}, 2'b10);
    watch(0);
    chk("bus_green_flash", {gt >= 2, rh}, {1'b1, 32'd0});
    cpu <= 1'b1;
    pass(2);
    chk("run_on", run_g, 1'b1);
    cpu <= 1'b0;
    pass(2);
    chk("run_off", run_g, 1'b0);
    cpu <= 1'b1;
    init_done <= 1'b1;
    pass(5);
    watch(1);
    chk("sys_green", {gh, rh}, {32'd40, 32'd0});
    wr(fbm_pkg::A_IRQ_MASK, 16'h0001);
    wr(fbm_pkg::A_SLV_CFG, 16'h0003);
    wr(fbm_pkg::A_CTRL, 16'h0001);
    for (int k = 0; k < 6; k++) wr(fbm_pkg::A_OUT_BASE + 5'(k), ow[16*k +: 16]);
    for (int k = 0; k < 6; k++) ret[16*k +: 16] = 16'($urandom);
    pass(45);
    watch(0);
    chk("bus_all_off", {rh, gh}, {32'd40, 32'd0});
    chk("no_xchg_out", sw, 96'h0);
    chk("xchg_idle", ndone, 0);
    rd(fbm_pkg::A_IN_BASE, 16'h0000);
    rd(fbm_pkg::A_OUT_BASE, 16'h0000);
    rd(5'h1f, 16'h0000);
    up <= 8'h01;
    pass(3);
    watch(0);
    chk("bus_part_off", {rt >= 2, gh}, {1'b1, 32'd0});
    up <= 8'h03;
    pass(60);
    chk("irq_up", o_irq, 1'b1);
    nd0 = ndone;
    watch(0);
    chk("bus_on", {gh, rh}, {32'd40, 32'd0});
    chk("xchg_done", ndone - nd0, 2);
    xchg_check();
    rd(fbm_pkg::A_STATUS, 16'h030b);
    rd(fbm_pkg::A_IRQ_STAT, 16'h0001);
    pass(3);
    chk("irq_clear", o_irq, 1'b0);
    ret = {$urandom, $urandom, $urandom};
    ow[47:32] = 16'($urandom);
    wr(fbm_pkg::A_OUT_BASE + 5'h2, ow[47:32]);
    pass(60);
    xchg_check();
    up <= 8'h01;
    pass(10);
    chk("loss_zero", sw, 96'h0);
    chk("irq_masked", o_irq, 1'b0);
    rd(fbm_pkg::A_IRQ_STAT, 16'h000a);
    pass(3);
    i_arst_n <= 1'b0;
    init_done <= 1'b0;
    init_fail <= 1'b1;
    pass(3);
    i_arst_n <= 1'b1;
    pass(40);
    watch(1);
    chk("sys_fail", {rt >= 2, gh}, {1'b1, 32'd0});
    wrap_up();
  end
endmodule

// file: tb/slave_station_model.sv
// Purpose: stand-in for the remote slave stations on the fieldbus
// Assumes: bench commands which stations are online and what they return
// Notes:   with no station online the return lines carry a toggling pattern
`timescale 1ns/1ps
module slave_station_model #(
  parameter int N = 8,
  parameter int W = 96
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire logic [N-1:0] i_up,
  input  wire logic [W-1:0] i_ret,
  input  wire logic [W-1:0] i_rx,
  output logic      [N-1:0] o_online,
  output logic      [W-1:0] o_tx,
  output logic      [W-1:0] o_rx_q
);
  // ---------------------------------------------------------------
  // station state
  // ---------------------------------------------------------------
  logic [W-1:0] junk_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_online <= '0;
      junk_q   <= {(W/16){16'ha5c3}};
      o_rx_q   <= '0;
    end else begin
      o_online <= i_up;
      junk_q   <= ~junk_q;
      if (|i_up) begin
        o_rx_q <= i_rx;
      end
    end
  end
  // released line: never hold a stale word that could pass by luck
  assign o_tx = (|o_online) ? i_ret : junk_q;
endmodule
